// ===== src/mgpwm_top.sv
`timescale 1ns/1ns
`include "mgpwm_defines.svh"
module mgpwm_top
  import mgpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`MGPWM_ADDR_W-1:0] addr,
  input wire logic [`MGPWM_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`MGPWM_DATA_W-1:0] rdata,
  output logic [`MGPWM_OUTS-1:0] ext_addr_pwm,
  output logic ext_addr_pwm_oe,
  output logic [`MGPWM_OUTS-1:0] peripheral_pin_matrix_pwm,
  output logic peripheral_pin_matrix_pwm_oe
);

  // ****************************************************************
  // Address window decode
  // ****************************************************************
  function automatic logic in_win(
    input logic [7:0] a,
    input logic [7:0] base,
    input logic [7:0] words
  );
    logic [7:0] top;
    top = base + 8'(words << 2);
    in_win = (a[1:0] == 2'b00) && (a >= base) && (a < top);
  endfunction

  logic [`MGPWM_CTRL_W-1:0] ctrl_q;
  mgpwm_cnt_t per_sh_q [`MGPWM_GROUPS];
  mgpwm_cnt_t duty_sh_q [`MGPWM_OUTS];
  mgpwm_cnt_t cnt [`MGPWM_GROUPS];
  logic [3:0] grp_pwm [`MGPWM_GROUPS];
  logic [`MGPWM_GROUPS-1:0] down;
  logic [`MGPWM_OUTS-1:0] all_pwm;
  logic [`MGPWM_DATA_W-1:0] rdata_d;
  logic [`MGPWM_DATA_W-1:0] rdata_q;
  logic [`MGPWM_OUTS-1:0] ext_q;
  logic [`MGPWM_OUTS-1:0] ppm_q;
  logic ext_oe_q;
  logic ppm_oe_q;
  logic wr_per;
  logic wr_duty;

  assign wr_per = wr && in_win(addr, `MGPWM_PER_BASE, 8'h04);
  assign wr_duty = wr && in_win(addr, `MGPWM_DUTY_BASE, 8'h10);

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `MGPWM_CTRL_RST;
    end else if (wr && (addr == `MGPWM_CTRL_OFS)) begin
      ctrl_q <= wdata[`MGPWM_CTRL_W-1:0];
    end
  end

  // ****************************************************************
  // Shadow period registers
  // ****************************************************************
  generate
    for (genvar g = 0; g < `MGPWM_GROUPS; g++) begin : g_per
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          per_sh_q[g] <= `MGPWM_PER_RST;
        end else if (wr_per && (addr[3:2] == 2'(g))) begin
          per_sh_q[g] <= wdata[15:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Shadow duty registers
  // ****************************************************************
  generate
    for (genvar i = 0; i < `MGPWM_OUTS; i++) begin : g_dsh
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          duty_sh_q[i] <= `MGPWM_DUTY_RST;
        end else if (wr_duty && (addr[5:2] == 4'(i))) begin
          duty_sh_q[i] <= wdata[15:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Four groups of four outputs
  // ****************************************************************
  generate
    for (genvar g = 0; g < `MGPWM_GROUPS; g++) begin : g_grp
      mgpwm_group u_grp (
        .clk(clk),
        .reset(reset),
        .enable(ctrl_q[`MGPWM_CTRL_EN]),
        .edge_mode(ctrl_q[`MGPWM_CTRL_EDGE]),
        .dbl_mode(ctrl_q[`MGPWM_CTRL_DBL]),
        .paired(ctrl_q[`MGPWM_CTRL_PAIR_LSB + g]),
        .period_sh(per_sh_q[g]),
        .duty0_sh(duty_sh_q[4*g]),
        .duty1_sh(duty_sh_q[4*g+1]),
        .duty2_sh(duty_sh_q[4*g+2]),
        .duty3_sh(duty_sh_q[4*g+3]),
        .pwm_q(grp_pwm[g]),
        .cnt_q(cnt[g]),
        .down_q(down[g])
      );
      assign all_pwm[4*g+3:4*g] = grp_pwm[g];
    end
  endgenerate

  // ****************************************************************
  // Output routing
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_q <= 16'h0000;
      ppm_q <= 16'h0000;
      ext_oe_q <= 1'b0;
      ppm_oe_q <= 1'b0;
    end else begin
      ext_oe_q <= ctrl_q[`MGPWM_CTRL_EN] && !ctrl_q[`MGPWM_CTRL_ROUTE];
      ppm_oe_q <= ctrl_q[`MGPWM_CTRL_EN] && ctrl_q[`MGPWM_CTRL_ROUTE];
      ext_q <= (ctrl_q[`MGPWM_CTRL_EN] && !ctrl_q[`MGPWM_CTRL_ROUTE]) ?
               all_pwm : 16'h0000;
      ppm_q <= (ctrl_q[`MGPWM_CTRL_EN] && ctrl_q[`MGPWM_CTRL_ROUTE]) ?
               all_pwm : 16'h0000;
    end
  end

  assign ext_addr_pwm = ext_q;
  assign ext_addr_pwm_oe = ext_oe_q;
  assign peripheral_pin_matrix_pwm = ppm_q;
  assign peripheral_pin_matrix_pwm_oe = ppm_oe_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr == `MGPWM_CTRL_OFS) begin
      rdata_d = {24'h00_0000, ctrl_q};
    end else if (addr == `MGPWM_STAT_OFS) begin
      rdata_d = {12'h000, all_pwm, down};
    end else if (in_win(addr, `MGPWM_PER_BASE, 8'h04)) begin
      rdata_d = {16'h0000, per_sh_q[addr[3:2]]};
    end else if (in_win(addr, `MGPWM_CNT_BASE, 8'h04)) begin
      rdata_d = {16'h0000, cnt[addr[3:2]]};
    end else if (in_win(addr, `MGPWM_DUTY_BASE, 8'h10)) begin
      rdata_d = {16'h0000, duty_sh_q[addr[5:2]]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd ? rdata_d : 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;

endmodule

// ===== src/mgpwm_defines.svh
`ifndef MGPWM_DEFINES_SVH
`define MGPWM_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define MGPWM_ADDR_W 8
`define MGPWM_DATA_W 32
`define MGPWM_CNT_W 16
`define MGPWM_GROUPS 4
`define MGPWM_PER_GROUP 4
`define MGPWM_OUTS 16

// ****************************************************************
// Register offsets
// ****************************************************************
`define MGPWM_CTRL_OFS 8'h00
`define MGPWM_STAT_OFS 8'h04
`define MGPWM_PER_BASE 8'h10
`define MGPWM_CNT_BASE 8'h20
`define MGPWM_DUTY_BASE 8'h40

// ****************************************************************
// Control fields
// ****************************************************************
`define MGPWM_CTRL_EN 0
`define MGPWM_CTRL_EDGE 1
`define MGPWM_CTRL_DBL 2
`define MGPWM_CTRL_ROUTE 3
`define MGPWM_CTRL_PAIR_LSB 4
`define MGPWM_CTRL_W 8

// ****************************************************************
// Reset values
// ****************************************************************
`define MGPWM_CTRL_RST 8'h00
`define MGPWM_PER_RST 16'h0000
`define MGPWM_DUTY_RST 16'h0000

`endif

// ===== src/mgpwm_pkg.sv
package mgpwm_pkg;
  typedef enum {MGPWM_UP, MGPWM_DOWN} mgpwm_phase_e;
  typedef logic [15:0] mgpwm_cnt_t;
endpackage

// ===== src/mgpwm_group.sv
`timescale 1ns/1ns
`include "mgpwm_defines.svh"
module mgpwm_group
  import mgpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic edge_mode,
  input wire logic dbl_mode,
  input wire logic paired,
  input wire mgpwm_cnt_t period_sh,
  input wire mgpwm_cnt_t duty0_sh,
  input wire mgpwm_cnt_t duty1_sh,
  input wire mgpwm_cnt_t duty2_sh,
  input wire mgpwm_cnt_t duty3_sh,
  output logic [3:0] pwm_q,
  output mgpwm_cnt_t cnt_q,
  output logic down_q
);

  mgpwm_phase_e phase_q;
  mgpwm_cnt_t per_q;
  mgpwm_cnt_t duty_q [4];
  mgpwm_cnt_t sh [4];
  logic start_ev;
  logic mid_ev;
  logic [3:0] ch;

  assign sh[0] = duty0_sh;
  assign sh[1] = duty1_sh;
  assign sh[2] = duty2_sh;
  assign sh[3] = duty3_sh;

  // ****************************************************************
  // Update points
  // ****************************************************************
  always_comb begin
    start_ev = 1'b0;
    mid_ev = 1'b0;
    if (edge_mode) begin
      start_ev = (cnt_q + 16'h0001) >= per_q;
    end else begin
      unique case (phase_q)
        MGPWM_UP: begin
          mid_ev = (cnt_q >= per_q) && (per_q != 16'h0000);
          // Zero period keeps reloading so a new period can start
          start_ev = (per_q == 16'h0000);
        end
        MGPWM_DOWN: start_ev = cnt_q <= 16'h0001;
      endcase
    end
  end

  // ****************************************************************
  // Counter and phase
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      phase_q <= MGPWM_UP;
    end else if (!enable) begin
      cnt_q <= 16'h0000;
      phase_q <= MGPWM_UP;
    end else if (edge_mode) begin
      phase_q <= MGPWM_UP;
      cnt_q <= start_ev ? 16'h0000 : cnt_q + 16'h0001;
    end else begin
      unique case (phase_q)
        MGPWM_UP: begin
          if (mid_ev) begin
            phase_q <= MGPWM_DOWN;
            cnt_q <= cnt_q - 16'h0001;
          end else if (per_q != 16'h0000) begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        MGPWM_DOWN: begin
          if (start_ev) begin
            phase_q <= MGPWM_UP;
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Active period and duties from shadows
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      per_q <= `MGPWM_PER_RST;
    end else if (!enable || start_ev) begin
      per_q <= period_sh;
    end
  end

  generate
    for (genvar k = 0; k < 4; k++) begin : g_duty
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          duty_q[k] <= `MGPWM_DUTY_RST;
        end else if (!enable || start_ev) begin
          duty_q[k] <= sh[k];
        end else if (mid_ev && dbl_mode) begin
          duty_q[k] <= sh[k];
        end
      end
      assign ch[k] = enable && (cnt_q < duty_q[k]);
    end
  endgenerate

  // ****************************************************************
  // Output pairing
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_q <= 4'h0;
    end else if (!enable) begin
      pwm_q <= 4'h0;
    end else if (paired) begin
      pwm_q <= {~ch[2], ch[2], ~ch[0], ch[0]};
    end else begin
      pwm_q <= ch;
    end
  end

  assign down_q = (phase_q == MGPWM_DOWN);

endmodule

// ===== test/mgpwm_gate_model.sv
`timescale 1ns/1ns
module mgpwm_gate_model (
  input wire logic clk,
  input wire logic [15:0] ext,
  input wire logic ext_oe,
  input wire logic [15:0] ppm,
  input wire logic ppm_oe,
  output logic [15:0] gate
);
  logic [15:0] last_q = 16'h0000;
  always @(posedge clk) begin
    if (ext_oe || ppm_oe) begin
      last_q <= gate;
    end
  end
  // Released lines show the inverse of their last level
  always_comb begin
    gate = ext_oe ? ext : (ppm_oe ? ppm : ~last_q);
  end
endmodule

// ===== test/mgpwm_props.sv
`timescale 1ns/1ns
`include "mgpwm_defines.svh"
module mgpwm_props
  import mgpwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`MGPWM_ADDR_W-1:0] addr,
  input wire logic [`MGPWM_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [`MGPWM_DATA_W-1:0] rdata,
  input wire logic [`MGPWM_OUTS-1:0] ext_addr_pwm,
  input wire logic ext_addr_pwm_oe,
  input wire logic [`MGPWM_OUTS-1:0] peripheral_pin_matrix_pwm,
  input wire logic peripheral_pin_matrix_pwm_oe
);
  logic [3:0] pair_q;
  logic [2:0] age_q;
  logic [15:0] pins;
  logic wc;
  assign pins = ext_addr_pwm | peripheral_pin_matrix_pwm;
  assign wc = wr && addr == 8'h00;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pair_q <= 4'h0;
      age_q <= 3'h0;
    end else if (wc) begin
      pair_q <= wdata[7:4];
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_oe_excl: assert property (
    !(ext_addr_pwm_oe && peripheral_pin_matrix_pwm_oe))
    else $error("both destinations enabled");
  a_ext_off_zero: assert property (
    !ext_addr_pwm_oe |-> ext_addr_pwm == 16'h0)
    else $error("address lines driven while off");
  a_matrix_off_zero: assert property (
    !peripheral_pin_matrix_pwm_oe |-> peripheral_pin_matrix_pwm == 16'h0)
    else $error("matrix driven while off");
  a_ctrl_readback: assert property (
    wc ##1 (rd && addr == 8'h00) |=>
    rdata == ($past(wdata, 2) & 32'h0000_00ff))
    else $error("control readback wrong");
  a_route_ext: assert property (
    wc && wdata[0] && !wdata[3] |-> ##[1:3] ext_addr_pwm_oe)
    else $error("address lines not enabled");
  a_route_matrix: assert property (
    wc && wdata[0] && wdata[3] |-> ##[1:3] peripheral_pin_matrix_pwm_oe)
    else $error("matrix not enabled");
  a_en_off_quiet: assert property (
    wc && !wdata[0] |-> ##4 pins == 16'h0 && !ext_addr_pwm_oe)
    else $error("outputs active after disable");
  a_pair_compl: assert property (
    age_q == 3'h7 && pair_q[0] &&
    (ext_addr_pwm_oe || peripheral_pin_matrix_pwm_oe) |->
    pins[1] != pins[0] && pins[3] != pins[2])
    else $error("pair not complementary");
  c_ext: cover property (ext_addr_pwm_oe && ext_addr_pwm[0]);
  c_matrix: cover property (peripheral_pin_matrix_pwm_oe && pins[1]);
  c_read: cover property (rd ##1 rdata != 32'h0);
endmodule
bind mgpwm_top mgpwm_props i_mgpwm_props (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ext_addr_pwm(ext_addr_pwm), .ext_addr_pwm_oe(ext_addr_pwm_oe),
  .peripheral_pin_matrix_pwm(peripheral_pin_matrix_pwm),
  .peripheral_pin_matrix_pwm_oe(peripheral_pin_matrix_pwm_oe));

// ===== test/multi_group_pwm_generator_tb_top.sv
`timescale 1ns/1ns
`include "mgpwm_defines.svh"
module multi_group_pwm_generator_tb_top;
  import mgpwm_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [15:0] ext, ppm, gate;
  logic ext_oe, ppm_oe;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 79;
  int n, d0, d1, per, c;
  bit p;
  always #10 clk = ~clk;
  mgpwm_top i_mgpwm_top (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_addr_pwm(ext),
    .ext_addr_pwm_oe(ext_oe), .peripheral_pin_matrix_pwm(ppm),
    .peripheral_pin_matrix_pwm_oe(ppm_oe));
  mgpwm_gate_model i_mgpwm_gate_model (.clk(clk), .ext(ext),
    .ext_oe(ext_oe), .ppm(ppm), .ppm_oe(ppm_oe), .gate(gate));
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    rd <= 0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    wr <= 0;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // High samples of one gate over a window, optional duty0 write
  task automatic run(int idx, int cyc, bit w, int d, output int hi);
    hi = 0;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk);
      wr <= w && i == 0;
      addr <= 8'h40;
      wdata <= 32'(d);
      @(negedge clk);
      hi += (gate[idx] === 1'b1);
    end
  endtask
  task automatic quiet();
    wr_reg(8'h00, 32'h0);
    run(0, 8, 0, 0, n);
    rd_reg(8'h04, 32'h0);
  endtask
  task automatic wait_rise(int idx);
    int i;
    i = 0;
    while (gate[idx] !== 1'b0 && i < 400) begin
      @(negedge clk);
      i++;
    end
    while (gate[idx] !== 1'b1 && i < 400) begin
      @(negedge clk);
      i++;
    end
    if (i >= 400) begin
      num_errors++;
      complete_run();
    end
  endtask
  function automatic int hi_of(bit edg, int d);
    return edg ? d : 2 * d - 1;
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h10, 32'h0);
    rd_reg(8'h54, 32'h0);
    wr_reg(8'h20, 32'h5);
    rd_reg(8'h20, 32'h0);
    wr_reg(8'h80, 32'h1);
    rd_reg(8'h80, 32'h0);
    wr_reg(8'h44, 32'ha5);
    rd_reg(8'h44, 32'ha5);
    rd_reg(8'h45, 32'h0);
    for (int t = 0; t < 4; t++) begin
      d0 = 1 + ($random(seed) & 7);
      d1 = 1 + ($random(seed) & 7);
      per = t[0] ? 10 : 20;
      p = t[0] ^ t[1];
      for (int g = 0; g < 4; g++) begin
        wr_reg(8'(8'h10 + 4 * g), 32'ha);
        wr_reg(8'(8'h40 + 16 * g), 32'(d0));
        wr_reg(8'(8'h44 + 16 * g), 32'(d1));
      end
      c = 1 + 2 * t[0] + 8 * t[1] + (p ? 8'hf0 : 0);
      wr_reg(8'h00, 32'(c));
      rd_reg(8'h00, 32'(c));
      run(0, 4 * per, 0, 0, n);
      for (int g = 0; g < 4; g++) begin
        run(4 * g, 3 * per, 0, 0, n);
        chk(n, 3 * hi_of(t[0], d0));
      end
      run(1, 3 * per, 0, 0, n);
      chk(n, p ? 3 * (per - hi_of(t[0], d0)) : 3 * hi_of(t[0], d1));
      quiet();
    end
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h10, 32'h14);
      wr_reg(8'h40, 32'h4);
      wr_reg(8'h00, 32'(1 + 4 * s));
      run(0, 80, 0, 0, n);
      wait_rise(0);
      run(0, 40, 1, 16, n);
      chk(n, s ? 19 : 7);
      run(0, 40, 0, 0, n);
      chk(n, 31);
      quiet();
    end
    complete_run();
  end
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule
